// ---- nv_trim_memory_control.sv ----
// non-volatile trim store controller with an AXI4-Lite register slave
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
module nv_trim_memory_control
  import nv_trim_pkg::*;
#(
  parameter int UNIT_CYCLES = TIMER_UNIT_CYCLES
) (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address taken
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data taken
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response taken
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address taken
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data taken
  output logic [1:0] cellOp, // command to the cell array
  output logic [7:0] cellMask, // cells acted on
  input wire logic [7:0] cellSense, // sensed cell values
  output logic [7:0] hvLevel, // pump setting for the cell op
  output logic progSupplyOn, // external program supply needed
  output logic [5:0] trimOffset, // trim read from the cells
  output logic [7:0] effPumpLevel, // trimmed pump level
  output logic nvBusy, // operation running
  output logic nvOk, // last operation succeeded
  output logic irq // unmasked event pending
);
  fsm_t state_r;
  logic [2:0] op_r;
  logic [1:0] attempts_r;
  logic timerLoad_r;
  logic [7:0] timerUnits_r;
  logic timerDone;
  logic doneEv_r;
  logic failEv_r;
  logic [2:0] ctrl_r;
  logic [7:0] readHv_r;
  logic [7:0] writeHv_r;
  logic [7:0] writeTimer_r;
  logic [7:0] readTimer_r;
  logic [7:0] pumpLevel_r;
  logic [1:0] irqStat_r;
  logic [1:0] irqMask_r;
  logic wrTake;
  logic rdTake;
  logic wrLow;
  logic startReq;
  logic softRst;
  logic irqClr;

  function automatic logic addrMapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    addrMapped = (w <= OFF_SOFT_RESET);
  endfunction

  function automatic logic [7:0] trimApply(input logic [7:0] lvl, input logic [5:0] t);
    logic [8:0] sum;
    sum = 9'h0;
    if (t[TRIM_SIGN_BIT]) begin
      sum = {1'b0, lvl} - {4'h0, t[4:0]};
      trimApply = sum[8] ? 8'h00 : sum[7:0];
    end else begin
      sum = {1'b0, lvl} + {4'h0, t[4:0]};
      trimApply = sum[8] ? 8'hff : sum[7:0];
    end
  endfunction

  function automatic logic verifyOk(input logic [2:0] op, input logic [7:0] s,
                                    input logic [7:0] m);
    if (op == OP_ERASE) begin
      verifyOk = ((s & m) == 8'h00);
    end else begin
      verifyOk = ((s & m) == m);
    end
  endfunction

  // bus handshakes: write needs address and data together
  assign wrTake = awvalid && wvalid && !bvalid;
  assign awready = wrTake;
  assign wready = wrTake;
  assign rdTake = arvalid && !rvalid;
  assign arready = rdTake;
  assign wrLow = wrTake && wstrb[0];
  assign startReq = wrLow && ({awaddr[7:2], 2'b00} == OFF_CONTROL)
                    && wdata[CTRL_START_BIT];
  assign softRst = wrLow && ({awaddr[7:2], 2'b00} == OFF_SOFT_RESET) && wdata[0];
  assign irqClr = rdTake && ({araddr[7:2], 2'b00} == OFF_IRQ_STATUS);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wrTake) begin
      bvalid <= 1'b1;
      bresp <= addrMapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // configuration registers; a soft reset restores them but starts no read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= 3'h0;
      cellMask <= RST_BIT_MASK;
      readHv_r <= RST_READ_HV;
      writeHv_r <= RST_WRITE_HV;
      writeTimer_r <= RST_WRITE_TIMER;
      readTimer_r <= RST_READ_TIMER;
      pumpLevel_r <= RST_PUMP_LEVEL;
      irqMask_r <= 2'h0;
    end else if (softRst) begin
      ctrl_r <= 3'h0;
      cellMask <= RST_BIT_MASK;
      readHv_r <= RST_READ_HV;
      writeHv_r <= RST_WRITE_HV;
      writeTimer_r <= RST_WRITE_TIMER;
      readTimer_r <= RST_READ_TIMER;
      pumpLevel_r <= RST_PUMP_LEVEL;
      irqMask_r <= 2'h0;
    end else if (wrLow) begin
      case ({awaddr[7:2], 2'b00})
        OFF_CONTROL: ctrl_r <= wdata[2:0];
        OFF_BIT_MASK: if (!nvBusy) cellMask <= wdata[7:0];
        OFF_READ_HV: readHv_r <= wdata[7:0];
        OFF_WRITE_HV: writeHv_r <= wdata[7:0];
        OFF_WRITE_TIMER: writeTimer_r <= wdata[7:0];
        OFF_READ_TIMER: readTimer_r <= wdata[7:0];
        OFF_PUMP_LEVEL: pumpLevel_r <= wdata[7:0];
        OFF_IRQ_MASK: irqMask_r <= wdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0;
    end else if (rdTake) begin
      rvalid <= 1'b1;
      rresp <= addrMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata <= 32'h0;
      case ({araddr[7:2], 2'b00})
        OFF_CONTROL: rdata[2:0] <= ctrl_r;
        OFF_BIT_MASK: rdata[7:0] <= cellMask;
        OFF_READ_HV: rdata[7:0] <= readHv_r;
        OFF_WRITE_HV: rdata[7:0] <= writeHv_r;
        OFF_WRITE_TIMER: rdata[7:0] <= writeTimer_r;
        OFF_READ_TIMER: rdata[7:0] <= readTimer_r;
        OFF_STATUS: begin
          rdata[STAT_BUSY_BIT] <= nvBusy;
          rdata[STAT_FITTED_BIT] <= FITTED;
          rdata[STAT_OK_BIT] <= nvOk;
        end
        OFF_PUMP_LEVEL: rdata[7:0] <= pumpLevel_r;
        OFF_EFF_LEVEL: rdata[7:0] <= effPumpLevel;
        OFF_TRIM: rdata[5:0] <= trimOffset;
        OFF_IRQ_STATUS: rdata[1:0] <= irqStat_r;
        OFF_IRQ_MASK: rdata[1:0] <= irqMask_r;
        default: ;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  nv_op_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) opTimer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(timerLoad_r),
    .units(timerUnits_r),
    .done(timerDone)
  );

  // operation sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_BOOT;
      op_r <= OP_READ;
      attempts_r <= 2'h0;
      cellOp <= CELL_IDLE;
      timerLoad_r <= 1'b0;
      timerUnits_r <= 8'h0;
      nvBusy <= 1'b0;
      nvOk <= 1'b0;
      trimOffset <= 6'h0;
      doneEv_r <= 1'b0;
      failEv_r <= 1'b0;
    end else begin
      timerLoad_r <= 1'b0;
      doneEv_r <= 1'b0;
      failEv_r <= 1'b0;
      case (state_r)
        ST_BOOT: begin
          op_r <= OP_READ;
          cellOp <= CELL_READ;
          timerUnits_r <= readTimer_r;
          timerLoad_r <= 1'b1;
          nvBusy <= 1'b1;
          state_r <= ST_CELL;
        end
        ST_IDLE: begin
          if (startReq) begin
            attempts_r <= 2'h1;
            case (wdata[2:0])
              OP_READ: begin
                op_r <= OP_READ;
                cellOp <= CELL_READ;
                timerUnits_r <= readTimer_r;
                timerLoad_r <= 1'b1;
                nvBusy <= 1'b1;
                nvOk <= 1'b0;
                state_r <= ST_CELL;
              end
              OP_ERASE, OP_PROGRAM: begin
                op_r <= wdata[2:0];
                cellOp <= (wdata[2:0] == OP_ERASE) ? CELL_ERASE : CELL_PROGRAM;
                timerUnits_r <= writeTimer_r;
                timerLoad_r <= 1'b1;
                nvBusy <= 1'b1;
                nvOk <= 1'b0;
                state_r <= ST_CELL;
              end
              default: ;
            endcase
          end
        end
        ST_CELL: begin
          if (timerDone) begin
            if (op_r == OP_READ) begin
              trimOffset <= cellSense[5:0];
              cellOp <= CELL_IDLE;
              nvOk <= 1'b1;
              timerUnits_r <= SETTLE_UNITS;
              timerLoad_r <= 1'b1;
              state_r <= ST_SETTLE;
            end else begin
              cellOp <= CELL_READ;
              timerUnits_r <= readTimer_r;
              timerLoad_r <= 1'b1;
              state_r <= ST_VERIFY;
            end
          end
        end
        ST_VERIFY: begin
          if (timerDone) begin
            if (verifyOk(op_r, cellSense, cellMask)) begin
              cellOp <= CELL_IDLE;
              nvOk <= 1'b1;
              timerUnits_r <= SETTLE_UNITS;
              timerLoad_r <= 1'b1;
              state_r <= ST_SETTLE;
            end else if (attempts_r != MAX_ATTEMPTS) begin
              attempts_r <= attempts_r + 2'h1;
              cellOp <= (op_r == OP_ERASE) ? CELL_ERASE : CELL_PROGRAM;
              timerUnits_r <= writeTimer_r;
              timerLoad_r <= 1'b1;
              state_r <= ST_CELL;
            end else begin
              cellOp <= CELL_IDLE;
              nvOk <= 1'b0;
              nvBusy <= 1'b0;
              failEv_r <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_SETTLE: begin
          if (timerDone) begin
            nvBusy <= 1'b0;
            doneEv_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // pump setting follows the cell command
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hvLevel <= 8'h0;
      progSupplyOn <= 1'b0;
    end else begin
      hvLevel <= (cellOp == CELL_READ) ? readHv_r : writeHv_r;
      progSupplyOn <= (cellOp == CELL_PROGRAM);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      effPumpLevel <= 8'h0;
    end else begin
      effPumpLevel <= trimApply(pumpLevel_r, trimOffset);
    end
  end

  // sticky events; a new event in the clearing cycle survives
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irqStat_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      irqStat_r[IRQ_DONE_BIT] <= (irqStat_r[IRQ_DONE_BIT] && !irqClr) || doneEv_r;
      irqStat_r[IRQ_FAIL_BIT] <= (irqStat_r[IRQ_FAIL_BIT] && !irqClr) || failEv_r;
      irq <= |(irqStat_r & irqMask_r);
    end
  end
endmodule // nv_trim_memory_control

// ---- nv_trim_pkg.sv ----
// constants and types shared by the non-volatile trim controller
package nv_trim_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_BIT_MASK = 8'h04;
  localparam logic [7:0] OFF_READ_HV = 8'h08;
  localparam logic [7:0] OFF_WRITE_HV = 8'h0c;
  localparam logic [7:0] OFF_WRITE_TIMER = 8'h10;
  localparam logic [7:0] OFF_READ_TIMER = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_PUMP_LEVEL = 8'h1c;
  localparam logic [7:0] OFF_EFF_LEVEL = 8'h20;
  localparam logic [7:0] OFF_TRIM = 8'h24;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
  localparam logic [7:0] OFF_SOFT_RESET = 8'h30;
  // field positions
  localparam int CTRL_START_BIT = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FITTED_BIT = 1;
  localparam int STAT_OK_BIT = 2;
  localparam int TRIM_SIGN_BIT = 5;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  // operation codes in the control register
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_ERASE = 3'h2;
  localparam logic [2:0] OP_PROGRAM = 3'h3;
  // cell array commands
  localparam logic [1:0] CELL_IDLE = 2'h0;
  localparam logic [1:0] CELL_READ = 2'h1;
  localparam logic [1:0] CELL_ERASE = 2'h2;
  localparam logic [1:0] CELL_PROGRAM = 2'h3;
  // reset values, retry limit and fitted flag
  localparam logic [7:0] RST_BIT_MASK = 8'h00;
  localparam logic [7:0] RST_READ_HV = 8'h96;
  localparam logic [7:0] RST_WRITE_HV = 8'h46;
  localparam logic [7:0] RST_WRITE_TIMER = 8'h40;
  localparam logic [7:0] RST_READ_TIMER = 8'h03;
  localparam logic [7:0] RST_PUMP_LEVEL = 8'h54;
  localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
  localparam logic FITTED = 1'b1;
  // timing: one timer unit of the write and read timers
  localparam int CLK_HZ = 20000000;
  localparam int TIMER_UNIT_US = 3125;
  localparam int TIMER_UNIT_CYCLES = TIMER_UNIT_US * (CLK_HZ / 1000000);
  localparam logic [7:0] SETTLE_UNITS = 8'h01;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_BOOT = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_CELL = 5'b00100,
    ST_VERIFY = 5'b01000,
    ST_SETTLE = 5'b10000
  } fsm_t;
endpackage

// ---- nv_op_timer.sv ----
// countdown of whole timer units, one done pulse at the end
module nv_op_timer
  import nv_trim_pkg::*;
#(
  parameter int UNIT_CYCLES = TIMER_UNIT_CYCLES
) (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic load, // start a new count
  input wire logic [7:0] units, // length in timer units
  output logic done // one-cycle pulse at the end
);
  logic [16:0] cycCnt_r;
  logic [7:0] remain_r;
  logic running_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cycCnt_r <= 17'h0;
      remain_r <= 8'h0;
      running_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cycCnt_r <= 17'h0;
        // a zero length still runs one unit
        remain_r <= (units == 8'h0) ? 8'h1 : units;
        running_r <= 1'b1;
      end else if (running_r) begin
        if (cycCnt_r == 17'(UNIT_CYCLES - 1)) begin
          cycCnt_r <= 17'h0;
          remain_r <= remain_r - 8'h1;
          if (remain_r == 8'h1) begin
            running_r <= 1'b0;
            done <= 1'b1;
          end
        end else begin
          cycCnt_r <= cycCnt_r + 17'h1;
        end
      end
    end
  end
endmodule // nv_op_timer

// ---- nv_trim_memory_control_sva.sv ----
// concurrent checks on the ports of the trim store controller
module nv_trim_memory_control_sva
  import nv_trim_pkg::*;
#(
  parameter int UNIT_CYCLES = TIMER_UNIT_CYCLES
) (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic awvalid, // write address valid
  input wire logic wvalid, // write data valid
  input wire logic awready, // write address taken
  input wire logic bvalid, // write response valid
  input wire logic arvalid, // read address valid
  input wire logic arready, // read address taken
  input wire logic rvalid, // read data valid
  input wire logic [1:0] cellOp, // cell command
  input wire logic [7:0] cellMask, // cells acted on
  input wire logic [5:0] trimOffset, // captured trim
  input wire logic progSupplyOn, // program supply request
  input wire logic nvBusy, // operation running
  input wire logic nvOk // last operation good
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence opLaunch;
    cellOp == CELL_IDLE ##1 cellOp != CELL_IDLE;
  endsequence
  sequence okHeld;
    (nvBusy && nvOk) [*2];
  endsequence
  busy_during_op_a: assert property (cellOp != CELL_IDLE |-> nvBusy)
    else $error("cell command active while not busy");
  op_start_flags_a: assert property (opLaunch |-> nvBusy && !nvOk)
    else $error("flags wrong at operation start");
  ok_kept_a: assert property (okHeld ##1 !nvBusy |-> nvOk)
    else $error("ok lost when busy fell");
  prog_supply_a: assert property (1'b1 |=> progSupplyOn == $past(cellOp == CELL_PROGRAM))
    else $error("program supply does not follow program command");
  mask_frozen_a: assert property ($past(nvBusy) && nvBusy |-> $stable(cellMask))
    else $error("cell mask changed while busy");
  trim_hold_a: assert property (!nvBusy && !$past(nvBusy) |-> $stable(trimOffset))
    else $error("trim changed while idle");
  aw_ready_a: assert property (awready == (awvalid && wvalid && !bvalid))
    else $error("write accept wrong");
  b_answer_a: assert property (awvalid && awready |=> bvalid)
    else $error("no write response");
  ar_ready_a: assert property (arready == (arvalid && !rvalid))
    else $error("read accept wrong");
  r_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("no read data");
endmodule // nv_trim_memory_control_sva

bind nv_trim_memory_control nv_trim_memory_control_sva #(.UNIT_CYCLES(UNIT_CYCLES)) u_sva (
  .sys_clk(sys_clk), .nrst(nrst), .awvalid(awvalid), .wvalid(wvalid), .awready(awready),
  .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .cellOp(cellOp),
  .cellMask(cellMask), .trimOffset(trimOffset), .progSupplyOn(progSupplyOn),
  .nvBusy(nvBusy), .nvOk(nvOk)
);

// ---- nv_cell_model.sv ----
// behavioural model of the eight-bit cell array behind the controller
module nv_cell_model
  import nv_trim_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic [1:0] cellOp, // command from the controller
  input wire logic [7:0] cellMask, // cells acted on
  input wire logic failOn, // sensing broken so verify fails
  output logic [7:0] cellSense // sensed cell values
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cells_r = 8'ha5;
  always @(posedge sys_clk) begin
    if (cellOp == CELL_ERASE) cells_r <= cells_r & ~cellMask;
    if (cellOp == CELL_PROGRAM) cells_r <= cells_r | cellMask;
  end
  // outside a read the sense lines show the inverse, never a stale value
  assign cellSense = (cellOp == CELL_READ && !failOn) ? cells_r : ~cells_r;
endmodule // nv_cell_model

// ---- nv_trim_memory_control_tb_top.sv ----
// register-level bench for the trim store controller
module nv_trim_memory_control_tb_top import nv_trim_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UNIT = 4;
  logic sys_clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, failOn = 1'b0, progSeen = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, progSupplyOn, nvBusy, nvOk, irq;
  logic [1:0] bresp, rresp, cellOp, prevOp, r;
  logic [7:0] cellMask, cellSense, hvLevel, effPumpLevel, hvSeen;
  logic [5:0] trimOffset;
  int fails = 0, numChecks = 0, eraseCount = 0, base = 0;
  int busyCount = 0, busyBase = 0, busyMin = 0;
  logic [7:0] rstAddr [7] = '{OFF_BIT_MASK, OFF_READ_HV, OFF_WRITE_HV, OFF_WRITE_TIMER,
    OFF_READ_TIMER, OFF_PUMP_LEVEL, OFF_IRQ_MASK};
  logic [31:0] rstVal [7] = '{32'h00, 32'h96, 32'h46, 32'h40, 32'h03, 32'h54, 32'h00};

  always #25 sys_clk = ~sys_clk;

  nv_trim_memory_control #(.UNIT_CYCLES(UNIT)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cellOp(cellOp),
    .cellMask(cellMask), .cellSense(cellSense), .hvLevel(hvLevel),
    .progSupplyOn(progSupplyOn), .trimOffset(trimOffset), .effPumpLevel(effPumpLevel),
    .nvBusy(nvBusy), .nvOk(nvOk), .irq(irq)
  );
  nv_cell_model u_cells (
    .sys_clk(sys_clk), .cellOp(cellOp), .cellMask(cellMask), .failOn(failOn),
    .cellSense(cellSense)
  );

  // counts erase attempts and records what the pump and supply saw
  always @(posedge sys_clk) begin
    prevOp <= cellOp;
    if (cellOp == CELL_ERASE && prevOp != CELL_ERASE) eraseCount <= eraseCount + 1;
    if (cellOp == CELL_ERASE && prevOp == CELL_ERASE) hvSeen <= hvLevel;
    if (progSupplyOn === 1'b1) progSeen <= 1'b1;
    if (nvBusy === 1'b1) busyCount <= busyCount + 1;
  end

  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp, input string s);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, s, got, exp);
    end
  endtask
  task automatic checkFlag(input logic got, input logic exp, input string s);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %b expected %b", $time, s, got, exp);
    end
  endtask
  task automatic axWrite(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel is released only at its own ready
    while (!(awDone && wDone)) begin
      @(posedge sys_clk);
      if (awready === 1'b1) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axRead(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    dv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    logic [1:0] rs;
    axWrite(a, dv, rs);
    checkWord({30'h0, rs}, {30'h0, RESP_OKAY}, "write response");
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
    logic [31:0] dv;
    logic [1:0] rs;
    axRead(a, dv, rs);
    checkWord(dv, exp, "read data");
    checkWord({30'h0, rs}, {30'h0, rsp}, "read response");
  endtask
  task automatic waitIdle();
    logic [31:0] dv;
    logic [1:0] rs;
    int n;
    n = 0;
    do begin
      axRead(OFF_STATUS, dv, rs);
      n++;
    end while (dv[STAT_BUSY_BIT] !== 1'b0 && n < 3000); // polls instead of re-issuing
    if (dv[STAT_BUSY_BIT] !== 1'b0) begin
      fails++;
      $display("[FAIL] %0t status poll timed out", $time);
    end
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    waitIdle();
    rdChk(OFF_STATUS, 32'h6, RESP_OKAY);
    rdChk(OFF_TRIM, 32'h25, RESP_OKAY);
    checkWord({24'h0, effPumpLevel}, 32'h4f, "trimmed level");
    note("boot read");
    for (int i = 0; i < 7; i++) rdChk(rstAddr[i], rstVal[i], RESP_OKAY);
    rdChk(8'h40, 32'h0, RESP_SLVERR);
    axWrite(8'h44, 32'h1, r);
    checkWord({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    axRead(OFF_IRQ_STATUS, d, r);
    note("reset values");
    wr(OFF_BIT_MASK, 32'h3f);
    busyBase = busyCount;
    wr(OFF_CONTROL, 32'h0a);
    waitIdle();
    rdChk(OFF_STATUS, 32'h6, RESP_OKAY);
    // busy spans erase, verify read and settle, plus a few cycles of sequencing
    busyMin = UNIT * (RST_WRITE_TIMER + RST_READ_TIMER + SETTLE_UNITS);
    checkFlag((busyCount - busyBase) inside {[busyMin:busyMin + 8]}, 1'b1, "busy time");
    checkWord({24'h0, hvSeen}, 32'h46, "erase pump level");
    checkWord(eraseCount, 32'h1, "erase attempts");
    checkFlag(irq, 1'b0, "masked irq");
    wr(OFF_IRQ_MASK, 32'h3);
    repeat (3) @(posedge sys_clk);
    checkFlag(irq, 1'b1, "unmasked irq");
    rdChk(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    checkFlag(irq, 1'b0, "cleared irq");
    wr(OFF_CONTROL, 32'h09);
    waitIdle();
    rdChk(OFF_TRIM, 32'h0, RESP_OKAY);
    rdChk(OFF_EFF_LEVEL, 32'h54, RESP_OKAY);
    note("erase and read");
    wr(OFF_BIT_MASK, 32'h01);
    wr(OFF_CONTROL, 32'h0b);
    waitIdle();
    rdChk(OFF_STATUS, 32'h6, RESP_OKAY);
    checkFlag(progSeen, 1'b1, "program supply");
    wr(OFF_CONTROL, 32'h09);
    wr(OFF_BIT_MASK, 32'h02);
    waitIdle();
    rdChk(OFF_BIT_MASK, 32'h01, RESP_OKAY);
    rdChk(OFF_TRIM, 32'h01, RESP_OKAY);
    rdChk(OFF_EFF_LEVEL, 32'h55, RESP_OKAY);
    note("program");
    wr(OFF_WRITE_HV, 32'h55);
    wr(OFF_SOFT_RESET, 32'h1);
    rdChk(OFF_STATUS, 32'h6, RESP_OKAY);
    rdChk(OFF_WRITE_HV, 32'h46, RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      if (k == 0 || k > 3) begin
        wr(OFF_CONTROL, 32'h8 | k);
        rdChk(OFF_STATUS, 32'h6, RESP_OKAY);
      end
    end
    note("soft reset and bad codes");
    axRead(OFF_IRQ_STATUS, d, r);
    wr(OFF_BIT_MASK, 32'h01);
    wr(OFF_IRQ_MASK, 32'h3);
    failOn <= 1'b1;
    base = eraseCount;
    wr(OFF_CONTROL, 32'h0a);
    waitIdle();
    rdChk(OFF_STATUS, 32'h2, RESP_OKAY);
    checkWord(eraseCount - base, 32'h3, "erase attempts");
    checkFlag(irq, 1'b1, "fail irq");
    rdChk(OFF_IRQ_STATUS, 32'h2, RESP_OKAY);
    failOn <= 1'b0;
    note("verify failure");
    end_of_test();
  end
endmodule // nv_trim_memory_control_tb_top
